// file: mdpc_loader.sv
// mdpc_loader.sv - one device of a chained parallel configuration loader
// assumes the shared data bus and config clock arrive synchronous to clock
// and that the open-drain lines are resolved with pull-ups outside
`timescale 1ns/1ps
`include "mdpc_map.svh"

module mdpc_loader
(
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         rstn,
   // scheme select and lane choice
   input  wire logic [`MDPC_SCHEME_W-1:0]    scheme_select_pins,
   input  wire logic                         lane_high,
   // shared flash bus and configuration clock
   input  wire logic [`MDPC_BUS_W-1:0]       flash_data,
   input  wire logic                         config_clock_in,
   input  wire logic                         flash_wait,
   // chain handoff
   input  wire logic                         chain_enable_in,
   output logic                              chain_enable_out,
   // open-drain shared lines
   input  wire logic                         config_complete_in,
   output logic                              config_complete_out,
   output logic                              config_complete_oen,
   input  wire logic                         config_status_in,
   output logic                              config_status_out,
   output logic                              config_status_oen,
   // captured configuration bytes toward the core
   output logic                              cfg_valid,
   input  wire logic                         cfg_ready,
   output logic [`MDPC_BYTE_W-1:0]           cfg_byte,
   // status
   output logic                              init_mode,
   output logic                              user_wait
);

   ////////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic scheme_ok(input logic [`MDPC_SCHEME_W-1:0] s);
      scheme_ok = (s == `MDPC_SCHEME_ACTIVE) || (s == `MDPC_SCHEME_PASSIVE);
   endfunction

   mdpc_pkg::mdpc_state_t state_ff;
   mdpc_pkg::mdpc_state_t nxt_state;
   logic [`MDPC_CNT_W-1:0] cnt_ff;
   logic [`MDPC_CNT_W-1:0] nxt_cnt;
   logic                   config_clock_output_ff;
   logic                   ceo_ff;
   logic                   init_ff;
   logic                   wait_ff;
   logic                   cvalid_ff;
   logic [`MDPC_BYTE_W-1:0] cbyte_ff;
   logic                   done_oen_ff;
   wire                    fifo_ovalid;
   wire [`MDPC_BYTE_W-1:0] fifo_odata;

   // every check below runs on the system clock and sleeps in reset
   default clocking chk_cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   wire is_master   = (scheme_select_pins == `MDPC_SCHEME_ACTIVE);
   wire sel_ok      = scheme_ok(scheme_select_pins);
   // a master always owns the bus; its enable input is grounded anyway
   wire enabled     = is_master || !chain_enable_in;
   wire config_clock_output_rise   = config_clock_in && !config_clock_output_ff;
   wire use_high    = lane_high && !is_master;
   wire [`MDPC_BYTE_W-1:0] lane_byte = use_high ?
      flash_data[`MDPC_HI_LSB +: `MDPC_BYTE_W] :
      flash_data[`MDPC_LO_LSB +: `MDPC_BYTE_W];
   wire loading     = (state_ff == mdpc_pkg::MDPC_LOAD);
   wire fifo_ready;
   wire stage_free  = !cvalid_ff || cfg_ready;
   // the fifo rides out short core stalls; if it fills, a config clock
   // edge is dropped, so the core must drain faster than bytes arrive
   wire take        = loading && enabled && config_clock_output_rise && fifo_ready;
   wire last_byte   = take && (cnt_ff == `MDPC_IMAGE_BYTES - 16'h0001);
   wire done        = (state_ff == mdpc_pkg::MDPC_DRAIN) ||
                      (state_ff == mdpc_pkg::MDPC_INIT);

   ////////////////////////////////////////////////////////////////////////
   // sequencing

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      unique case (state_ff)
         mdpc_pkg::MDPC_WAIT_EN:
            if (enabled && sel_ok)
               nxt_state = mdpc_pkg::MDPC_LOAD;
         mdpc_pkg::MDPC_LOAD:
         begin
            if (take)
               nxt_cnt = cnt_ff + 16'h0001;
            if (last_byte)
               nxt_state = mdpc_pkg::MDPC_DRAIN;
         end
         mdpc_pkg::MDPC_DRAIN:
            if (config_complete_in)
               nxt_state = mdpc_pkg::MDPC_INIT;
         mdpc_pkg::MDPC_INIT:
            nxt_state = mdpc_pkg::MDPC_INIT;
         default:
            nxt_state = mdpc_pkg::MDPC_WAIT_EN;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         state_ff <= mdpc_pkg::MDPC_WAIT_EN;
         cnt_ff   <= '0;
         config_clock_output_ff  <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         config_clock_output_ff  <= config_clock_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         ceo_ff  <= 1'b1;
         done_oen_ff <= 1'b0;
         init_ff <= 1'b0;
         wait_ff <= 1'b0;
      end
      else
      begin
         ceo_ff  <= !(done || last_byte);
         done_oen_ff <= done || last_byte;
         init_ff <= (nxt_state == mdpc_pkg::MDPC_INIT);
         wait_ff <= init_ff && flash_wait;
      end
   end

   assign chain_enable_out    = ceo_ff;
   // open-drain: output is always 0, enable low means pulling the line
   assign config_complete_out = 1'b0;
   assign config_complete_oen = done_oen_ff;
   assign config_status_out   = 1'b0;
   assign config_status_oen   = init_ff;
   assign init_mode           = init_ff;
   assign user_wait           = wait_ff;

   ////////////////////////////////////////////////////////////////////////
   // byte path

   mdpc_fifo
   #(
      .WIDTH (`MDPC_BYTE_W),
      .DEPTH (`MDPC_FIFO_DEPTH)
   )
   u_fifo
   (
      .clock     (clock),
      .rstn      (rstn),
      .in_valid  (take),
      .in_ready  (fifo_ready),
      .in_data   (lane_byte),
      .out_valid (fifo_ovalid),
      .out_ready (stage_free),
      .out_data  (fifo_odata)
   );

   // output register stage so the byte port comes from flip-flops
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         cvalid_ff <= 1'b0;
         cbyte_ff  <= '0;
      end
      else if (stage_free)
      begin
         cvalid_ff <= fifo_ovalid;
         cbyte_ff  <= fifo_odata;
      end
   end

   assign cfg_valid = cvalid_ff;
   assign cfg_byte  = cbyte_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks

   ceo_after_last_a: assert property (
      last_byte |=> !chain_enable_out)
      else $error("chain enable not asserted after last byte");

   ceo_low_stays_a: assert property (
      !chain_enable_out |=> !chain_enable_out)
      else $error("chain enable released after done");

   done_holds_low_a: assert property (
      (state_ff == mdpc_pkg::MDPC_LOAD) |-> !config_complete_oen)
      else $error("complete line released before load finished");

   done_release_a: assert property (
      !chain_enable_out |-> config_complete_oen)
      else $error("complete line held after done");

   init_together_a: assert property (
      (done && config_complete_in) |-> ##[1:2] init_mode)
      else $error("init not entered after line high");

   disabled_ignore_a: assert property (
      (chain_enable_in && !is_master) |-> !take)
      else $error("disabled slave captured a byte");

   od_never_high_a: assert property (
      !config_complete_out && !config_status_out)
      else $error("open-drain pin driven high");

   wait_ignored_a: assert property (
      !init_mode |=> !user_wait)
      else $error("wait seen while configuring");

   // lane checks use the strap pins directly, not the internal select
   lane_pick_a: assert property (
      (take && (is_master || !lane_high)) |->
         (lane_byte == flash_data[`MDPC_LO_LSB +: `MDPC_BYTE_W]))
      else $error("low lane byte mismatch");

   lane_high_a: assert property (
      (take && !is_master && lane_high) |->
         (lane_byte == flash_data[`MDPC_HI_LSB +: `MDPC_BYTE_W]))
      else $error("high lane byte mismatch");

   stall_seen_c: cover property (@(posedge clock) disable iff (!rstn)
      take && cvalid_ff && !cfg_ready);

   load_seen_c: cover property (@(posedge clock) disable iff (!rstn)
      take);
   handoff_seen_c: cover property (@(posedge clock) disable iff (!rstn)
      $fell(chain_enable_out));
   init_seen_c: cover property (@(posedge clock) disable iff (!rstn)
      $rose(init_mode));

endmodule

// file: mdpc_map.svh
// mdpc_map.svh - constants for the chained parallel configuration loader
// assumes inclusion by its bare name from design files
`ifndef MDPC_MAP_SVH
`define MDPC_MAP_SVH

// scheme select encodings, four select pins
`define MDPC_SCHEME_W        4
`define MDPC_SCHEME_ACTIVE   4'hA
`define MDPC_SCHEME_PASSIVE  4'h5

// data bus lanes
`define MDPC_BUS_W           16
`define MDPC_BYTE_W          8
`define MDPC_LO_LSB          0
`define MDPC_HI_LSB          8

// configuration image length in bytes per device
`define MDPC_IMAGE_BYTES     16'h0040
`define MDPC_CNT_W           16

// buffer shape
`define MDPC_FIFO_DEPTH      8

`endif

// file: mdpc_pkg.sv
// mdpc_pkg.sv - types shared by the configuration loader
// assumes mdpc_map.svh is compiled alongside
package mdpc_pkg;

   typedef enum logic [3:0]
   {
      MDPC_WAIT_EN = 4'h1,
      MDPC_LOAD    = 4'h2,
      MDPC_DRAIN   = 4'h4,
      MDPC_INIT    = 4'h8
   } mdpc_state_t;

   // one open-drain pin: in, out, output enable (low = drive)
   typedef struct packed
   {
      logic pin_in;
      logic pin_out;
      logic pin_oen;
   } mdpc_od_t;

endpackage

// file: mdpc_fifo.sv
// mdpc_fifo.sv - small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module mdpc_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rstn,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      cnt_ff;
   wire              push;
   wire              pop;

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rd_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clock)
   begin
      if (push)
         mem_ff[wr_ff] <= in_data;
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (push)
            wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         if (pop)
            rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   fifo_no_overflow_a: assert property (@(posedge clock) disable iff (!rstn)
      cnt_ff <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");

endmodule

// file: mdpc_flash_model.sv
// mdpc_flash_model.sv - flash data and config clock source for the bench
// assumes one clock; start pulses for one cycle while idle
`timescale 1ns/1ps
`include "mdpc_map.svh"
module mdpc_flash_model
(
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   rstn,
   // control
   input  wire logic                   start,
   input  wire logic                   slow,
   output logic                        busy,
   // shared bus toward the loaders
   output logic [`MDPC_BUS_W-1:0]      flash_data,
   output logic                        config_clock_out
);
   logic [15:0] idx_ff;
   logic [1:0]  ph_ff;
   logic        hi_w;
   logic        last_w;
   assign hi_w   = busy && (ph_ff == 2'h0);
   assign last_w = ph_ff == (slow ? 2'h3 : 2'h1);
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         busy <= 1'b0;
         ph_ff <= 2'h0;
         config_clock_out <= 1'b0;
         flash_data <= 16'h0000;
      end
      else
      begin
         // clock stands low between bytes; released data keeps toggling
         config_clock_out <= hi_w;
         flash_data <= hi_w ? {idx_ff[7:0] ^ 8'hC5, idx_ff[7:0] ^ 8'h3C}
                            : ~flash_data;
         if (start && !busy)
         begin
            busy <= 1'b1;
            idx_ff <= 16'h0000;
            ph_ff <= 2'h0;
         end
         else if (busy)
         begin
            ph_ff <= last_w ? 2'h0 : ph_ff + 2'h1;
            if (last_w)
               idx_ff <= idx_ff + 16'h0001;
            if (last_w && idx_ff == `MDPC_IMAGE_BYTES - 16'h0001)
               busy <= 1'b0;
         end
      end
   end
endmodule

// file: tb_multi_device_parallel_config_chain.sv
// tb_multi_device_parallel_config_chain.sv - self-checking loader bench
// assumes mdpc_loader, mdpc_flash_model and mdpc_map.svh compiled first
`timescale 1ns/1ps
module tb_multi_device_parallel_config_chain;
   logic        clock, rstn, lane_high, flash_wait, chain_enable_in;
   logic [3:0]  scheme_select_pins;
   logic [15:0] flash_data;
   logic        config_clock_in, chain_enable_out, cfg_valid, cfg_ready;
   logic        config_complete_in, config_complete_out, config_complete_oen;
   logic        config_status_in, config_status_out, config_status_oen;
   logic [7:0]  cfg_byte;
   logic        init_mode, user_wait, start, slow, busy, other_hold, hi_exp;
   int          n_errors, check_count, rx;

   mdpc_loader dut_u (.clock(clock), .rstn(rstn),
      .scheme_select_pins(scheme_select_pins), .lane_high(lane_high),
      .flash_data(flash_data), .config_clock_in(config_clock_in),
      .flash_wait(flash_wait), .chain_enable_in(chain_enable_in),
      .chain_enable_out(chain_enable_out),
      .config_complete_in(config_complete_in),
      .config_complete_out(config_complete_out),
      .config_complete_oen(config_complete_oen),
      .config_status_in(config_status_in),
      .config_status_out(config_status_out),
      .config_status_oen(config_status_oen), .cfg_valid(cfg_valid),
      .cfg_ready(cfg_ready), .cfg_byte(cfg_byte), .init_mode(init_mode),
      .user_wait(user_wait));
   mdpc_flash_model flash_u (.clock(clock), .rstn(rstn), .start(start),
      .slow(slow), .busy(busy), .flash_data(flash_data),
      .config_clock_out(config_clock_in));

   // pulled-up shared lines; other_hold is a later device still loading
   assign config_complete_in = (config_complete_oen | config_complete_out)
                               & ~other_hold;
   assign config_status_in = config_status_oen | config_status_out;

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic run_image(input logic s, input int stall);
      start = 1'b1;
      slow = s;
      step(1);
      start = 1'b0;
      // core stall in mid-image; the fifo must hold the bytes meanwhile
      if (stall > 0)
      begin
         step(20);
         cfg_ready = 1'b0;
         step(stall);
         cfg_ready = 1'b1;
      end
      for (int i = 0; i < 1000 && busy !== 1'b0; i++)
         step(1);
      step(3);
   endtask

   task automatic do_reset(input logic [3:0] code);
      scheme_select_pins = code;
      rstn = 1'b0;
      rx = 0;
      step(10);
      check("ceo_rst", chain_enable_out, 1);
      check("done_oen_rst", config_complete_oen, 0);
      check("stat_oen_rst", config_status_oen, 0);
      rstn = 1'b1;
      step(1);
   endtask

   // every byte shown must be the next one of the selected lane
   always @(posedge clock)
      if (rstn === 1'b1 && cfg_valid === 1'b1 && cfg_ready === 1'b1)
      begin
         check("cfg_byte", {8'h00, cfg_byte},
               {8'h00, rx[7:0] ^ (hi_exp ? 8'hC5 : 8'h3C)});
         rx++;
      end

   ////////////////////////////////////////////////////////////////////////
   task automatic test_master;
      lane_high = 1'b1;
      hi_exp = 1'b0;
      chain_enable_in = 1'b0;
      other_hold = 1'b1;
      flash_wait = 1'b1;
      do_reset(4'hA);
      run_image(1'b0, 12);
      check("bytes", rx, 64);
      check("ceo", chain_enable_out, 0);
      check("done_oen", config_complete_oen, 1);
      check("init_held", init_mode, 0);
      check("wait_cfg", user_wait, 0);
      other_hold = 1'b0;
      step(2);
      check("init", init_mode, 1);
      check("stat_oen", config_status_oen, 1);
      check("wait_user", user_wait, 1);
      flash_wait = 1'b0;
      step(2);
      check("wait_drop", user_wait, 0);
      $display("master chain test done");
   endtask

   task automatic test_slave(input logic hi);
      lane_high = hi;
      hi_exp = hi;
      chain_enable_in = 1'b1;
      other_hold = 1'b0;
      do_reset(4'h5);
      run_image(1'b0, 0);
      check("off_bytes", rx, 0);
      check("off_ceo", chain_enable_out, 1);
      check("off_init", init_mode, 0);
      chain_enable_in = 1'b0;
      step(2);
      run_image(1'b1, 0);
      check("bytes", rx, 64);
      check("ceo", chain_enable_out, 0);
      step(2);
      check("init", init_mode, 1);
      $display("slave lane %0d test done", hi);
   endtask

   task automatic test_bad_scheme;
      chain_enable_in = 1'b0;
      do_reset(4'h0);
      run_image(1'b0, 0);
      check("bad_bytes", rx, 0);
      check("bad_ceo", chain_enable_out, 1);
      $display("bad scheme test done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial
   begin
      repeat (4000) @(posedge clock);
      n_errors++;
      end_of_test();
   end

   initial
   begin
      {rstn, start, slow, other_hold, flash_wait, hi_exp} = 6'h00;
      {lane_high, chain_enable_in, cfg_ready} = 3'h3;
      scheme_select_pins = 4'h0;
      n_errors = 0;
      check_count = 0;
      rx = 0;
      test_master();
      test_slave(1'b0);
      test_slave(1'b1);
      test_bad_scheme();
      end_of_test();
   end
endmodule
